// [verilog/fhr_defines.svh]
// Constants for the flash hardware reset and output disable block.
// Assumes a 200 MHz core clock; included by its bare name.
// What this block does
// - Reset low aborts work, floats outputs, clears configuration, ignores commands.
// - Reset returns the command state machine to array read.
// - Reset during program or erase holds ready_busy_n low, 1 to 7 us.
// - Reset with no program or erase running completes within 500 ns.
// - A bank idle at reset is readable 500 ns after reset asserts.
// - Output enable high keeps the data outputs in high impedance.
`ifndef FHR_DEFINES_SVH
`define FHR_DEFINES_SVH

`define FHR_CLK_PERIOD_PS  5000
`define FHR_T_IDLE_NS      500
`define FHR_T_BUSY_NS      7000
`define FHR_T_HOST_NS      11000
// Longest times, so round down
`define FHR_IDLE_CYC  ((`FHR_T_IDLE_NS * 1000) / `FHR_CLK_PERIOD_PS)
`define FHR_BUSY_CYC  ((`FHR_T_BUSY_NS * 1000) / `FHR_CLK_PERIOD_PS)
`define FHR_CNT_W     11
`define FHR_CFG_W     16
`define FHR_CFG_RST   16'h0000
`define FHR_DATA_W    32
`define FHR_BANKS     2

`endif

// [verilog/fhr_pkg.sv]
// Types for the flash hardware reset and output disable block.
// Assumes fhr_defines.svh is compiled alongside.
package fhr_pkg;
    // Reset sequencing states, one-hot
    typedef enum logic [2:0] {
        FHR_HELD    = 3'b001,
        FHR_RECOVER = 3'b010,
        FHR_READY   = 3'b100
    } fhr_state_t;
endpackage

// [verilog/fhr_bank_timer.sv]
// Per-bank recovery timer started when the reset pin falls.
// Assumes start_i is a one-cycle pulse synchronous to clock_i.
`timescale 1ns/1ps
`default_nettype none
module fhr_bank_timer #(
    parameter int                 CNT_W    = 11,
    parameter logic [CNT_W-1:0]   IDLE_CYC = 11'd100,
    parameter logic [CNT_W-1:0]   BUSY_CYC = 11'd1400
) (
    // Clock and reset
    input  wire logic  clock_i,
    input  wire logic  rst_i,
    // Control
    input  wire logic  start_i,
    input  wire logic  busy_i,
    // Status
    output logic       done_o,
    output logic       busy_recov_o
);
    logic [CNT_W-1:0] cnt_reg;
    logic             was_busy_reg;

    // Busy bank needs the long internal reset, idle bank the short one
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_reg      <= '0;
            was_busy_reg <= 1'b0;
        end else if (start_i) begin
            cnt_reg      <= busy_i ? BUSY_CYC : IDLE_CYC;
            was_busy_reg <= busy_i;
        end else if (cnt_reg != '0) begin
            cnt_reg      <= cnt_reg - 1'b1;
        end
    end

    assign done_o       = (cnt_reg == '0);
    assign busy_recov_o = was_busy_reg && (cnt_reg != '0);

    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);

    // Count loads at the start edge and reads zero 101 edges later
    idle_done_a: assert property (start_i && !busy_i |-> ##[1:101] done_o)
        else $error("idle bank recovery exceeded 500 ns");
    busy_hold_a: assert property (start_i && busy_i |=> !done_o [*8])
        else $error("busy bank recovery ended too early");
endmodule // fhr_bank_timer
`default_nettype wire

// [verilog/fhr_reset_ctrl.sv]
// Hardware reset input and output disable control of the flash core.
// Assumes all inputs are synchronous to clock_i except reset_n_i, which
// acts at once; bank busy flags come from the embedded algorithm engine.
`timescale 1ns/1ps
`default_nettype none
`include "fhr_defines.svh"
module fhr_reset_ctrl #(
    parameter int NUM_BANKS = `FHR_BANKS,
    parameter int DATA_W    = `FHR_DATA_W,
    parameter int CFG_W     = `FHR_CFG_W
) (
    // Clock and system reset
    input  wire logic                 clock_i,
    input  wire logic                 rst_i,
    // Host pins
    input  wire logic                 reset_n_i,
    input  wire logic                 output_enable_n_i,
    input  wire logic                 chip_enable_n_i,
    // Host command side
    input  wire logic                 read_i,
    input  wire logic                 read_bank_i,
    input  wire logic                 cfg_write_i,
    input  wire logic [CFG_W-1:0]     cfg_data_i,
    input  wire logic                 mode_write_i,
    // Core side
    input  wire logic [NUM_BANKS-1:0] bank_busy_i,
    input  wire logic [DATA_W-1:0]    array_data_i,
    // Data pins
    output logic [DATA_W-1:0]         data_o,
    output logic                      data_oe_n_o,
    // Status and control to the core
    output logic                      ready_busy_n_o,
    output logic                      abort_o,
    output logic                      array_read_o,
    output logic                      cmd_accept_o,
    output logic [CFG_W-1:0]          cfg_o,
    output logic [NUM_BANKS-1:0]      bank_ready_o
);
    // Pin low resets at once, without a clock edge
    logic hw_rst;
    assign hw_rst = rst_i | ~reset_n_i;

    fhr_pkg::fhr_state_t   state_reg;
    fhr_pkg::fhr_state_t   state_next;
    logic                  pin_low_reg;
    logic                  start;
    logic [NUM_BANKS-1:0]  done;
    logic [NUM_BANKS-1:0]  busy_recov;
    logic                  read_ok;

    // Pin level seen by the clock; timers must run while the pin is low
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pin_low_reg <= 1'b0;
        end else begin
            pin_low_reg <= ~reset_n_i;
        end
    end
    // Busy flags are sampled here, before the abort takes hold
    assign start = ~reset_n_i & ~pin_low_reg;

    // One recovery timer per bank
    genvar b;
    generate
        for (b = 0; b < NUM_BANKS; b++) begin : g_bank
            fhr_bank_timer #(
                .CNT_W    (`FHR_CNT_W),
                .IDLE_CYC (`FHR_CNT_W'(`FHR_IDLE_CYC)),
                .BUSY_CYC (`FHR_CNT_W'(`FHR_BUSY_CYC))
            ) u_timer (
                .clock_i      (clock_i),
                .rst_i        (rst_i),
                .start_i      (start),
                .busy_i       (bank_busy_i[b]),
                .done_o       (done[b]),
                .busy_recov_o (busy_recov[b])
            );
        end
    endgenerate

    // Sequencer: held by the pin, then recovering, then ready
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            fhr_pkg::FHR_HELD:    state_next = fhr_pkg::FHR_RECOVER;
            fhr_pkg::FHR_RECOVER: if (&done) state_next = fhr_pkg::FHR_READY;
            fhr_pkg::FHR_READY:   state_next = fhr_pkg::FHR_READY;
            default:              state_next = fhr_pkg::FHR_HELD;
        endcase
    end

    always_ff @(posedge clock_i or posedge hw_rst) begin
        if (hw_rst) begin
            state_reg <= fhr_pkg::FHR_HELD;
        end else begin
            state_reg <= state_next;
        end
    end

    // Abort stands for the whole pulse; commands refused until ready
    always_ff @(posedge clock_i or posedge hw_rst) begin
        if (hw_rst) begin
            abort_o      <= 1'b1;
            cmd_accept_o <= 1'b0;
        end else begin
            abort_o      <= 1'b0;
            cmd_accept_o <= (state_next == fhr_pkg::FHR_READY);
        end
    end

    // Configuration register, cleared by the pin
    always_ff @(posedge clock_i or posedge hw_rst) begin
        if (hw_rst) begin
            cfg_o <= `FHR_CFG_RST;
        end else if (cfg_write_i && cmd_accept_o) begin
            cfg_o <= cfg_data_i;
        end
    end

    // Command machine mode: reset always lands in array read
    always_ff @(posedge clock_i or posedge hw_rst) begin
        if (hw_rst) begin
            array_read_o <= 1'b1;
        end else if (mode_write_i && cmd_accept_o) begin
            array_read_o <= 1'b0;
        end else if (read_i && cmd_accept_o) begin
            array_read_o <= 1'b1;
        end
    end

    // A bank idle at reset is readable once its short timer ends,
    // even while the other bank is still recovering
    always_ff @(posedge clock_i or posedge hw_rst) begin
        if (hw_rst) begin
            bank_ready_o <= '0;
        end else begin
            bank_ready_o <= done;
        end
    end

    // Busy flag stays low through internal reset of a busy bank
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ready_busy_n_o <= 1'b1;
        end else begin
            ready_busy_n_o <= ~(|busy_recov | |bank_busy_i);
        end
    end

    // Outputs drive only with chip and output enable low and bank ready
    assign read_ok = ~chip_enable_n_i & ~output_enable_n_i
                   & bank_ready_o[read_bank_i];
    always_ff @(posedge clock_i or posedge hw_rst) begin
        if (hw_rst) begin
            data_oe_n_o <= 1'b1;
            data_o      <= '0;
        end else begin
            data_oe_n_o <= ~read_ok;
            if (read_ok) begin
                data_o <= array_data_i;
            end
        end
    end

    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);

    oe_float_a: assert property (output_enable_n_i |=> data_oe_n_o)
        else $error("data driven with output enable high");
    pin_float_a: assert property (!reset_n_i |-> data_oe_n_o && abort_o)
        else $error("outputs driven or no abort during reset");
    cfg_clear_a: assert property (!reset_n_i |-> cfg_o == `FHR_CFG_RST)
        else $error("configuration not cleared by reset");
    no_cmd_a: assert property (!reset_n_i ##1 !reset_n_i |-> !cmd_accept_o)
        else $error("command accepted during reset");
    array_read_a: assert property ($rose(reset_n_i) |-> array_read_o)
        else $error("reset did not return to array read");
    ryby_low_a: assert property (start && |bank_busy_i |=> ##1 !ready_busy_n_o [*4])
        else $error("ready_busy_n not held low after busy reset");
    bank_read_a: assert property (reset_n_i && done[0] ##1 reset_n_i |-> bank_ready_o[0])
        else $error("idle bank not readable after recovery");
    async_rst_a: assert property (!reset_n_i |-> state_reg == fhr_pkg::FHR_HELD)
        else $error("reset did not act at once");

    // The mode must sit in array read for the whole pulse, not only
    // at its end, so a read straight after release sees array data
    mode_hold_a: assert property (!reset_n_i |-> array_read_o)
        else $error("command machine left array read during reset");

    // A refused write must leave the register alone; a pin fall in
    // between may still clear it, so that case is excused
    cfg_hold_a: assert property (!cmd_accept_o && reset_n_i
                                 |=> !reset_n_i
                                     || cfg_o == $past(cfg_o))
        else $error("configuration changed while commands refused");

    // Driven data is the array word seen one edge earlier
    read_data_a: assert property (!data_oe_n_o && reset_n_i
                                  |-> data_o == $past(array_data_i))
        else $error("read data does not follow array contents");

    // Commands come back only when every bank is readable again
    cmd_ready_a: assert property (cmd_accept_o |-> &bank_ready_o)
        else $error("commands accepted before banks recovered");

    // Main scenarios: idle reset, busy reset, plain read and the
    // end of a long internal reset

    idle_reset_c: cover property (start && !(|bank_busy_i) ##[1:120] cmd_accept_o);
    busy_reset_c: cover property (start && bank_busy_i[0] ##[1:20] !ready_busy_n_o);
    read_out_c:   cover property (cmd_accept_o && !data_oe_n_o);
    busy_done_c:  cover property (!ready_busy_n_o ##1 ready_busy_n_o);

    // Limitation: the timers run only from the pin; a system reset
    // alone leaves them idle, so banks read ready one edge after it.
    // Trade-off: one shared start pulse keeps both banks in step,
    // at the cost of sampling the busy flags on a single edge only.
endmodule // fhr_reset_ctrl
`default_nettype wire

// [verification/fhr_host_model.sv]
// Host controller model driving the hardware reset pin of the flash.
// Assumes one clock; pulse_len_i is sampled with the start_i pulse.
`timescale 1ns/1ps
`default_nettype none
module fhr_host_model (
    // Clock and supply reset
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    // Requests from the bench
    input  wire logic       start_i,
    input  wire logic [7:0] pulse_len_i,
    // Reset pin, active low
    output logic            reset_n_o
);
    logic [7:0] cnt_reg;

    // Pin held low through supply ramp, then pulses on request
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            reset_n_o <= 1'b0;
            cnt_reg   <= 8'h04;
        end else if (start_i) begin
            reset_n_o <= 1'b0;
            cnt_reg   <= pulse_len_i;
        end else if (cnt_reg != 8'h00) begin
            cnt_reg <= cnt_reg - 8'h01;
        end else begin
            reset_n_o <= 1'b1;
        end
    end
endmodule // fhr_host_model
`default_nettype wire

// [verification/testbench.sv]
// Self-checking bench for the reset and output disable block.
// Assumes the host model above drives the reset pin.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clock_i = 0, rst_i = 1, oe_n = 1, ce_n = 1, rd = 0, rbank = 0;
    logic cfg_wr = 0, mode_wr = 0, start = 0;
    logic [15:0] cfg_d = 16'h0000, v;
    logic [1:0]  busy = 2'h0, bank_ready_o;
    logic [31:0] arr = 32'h0, data_o;
    logic [7:0]  plen = 8'h08;
    logic        reset_n, data_oe_n_o, ready_busy_n_o, abort_o;
    logic        array_read_o, cmd_accept_o;
    logic [15:0] cfg_o;
    int          n_fail = 0, n_tests = 0, n, cyc = 0, t0;

    // 200 MHz clock and a free cycle count for timing checks
    always #2.5 clock_i = ~clock_i;
    always @(posedge clock_i) cyc++;

    fhr_host_model i_host (.clock_i(clock_i), .rst_i(rst_i),
        .start_i(start), .pulse_len_i(plen), .reset_n_o(reset_n));
    fhr_reset_ctrl i_dut (.clock_i(clock_i), .rst_i(rst_i),
        .reset_n_i(reset_n), .output_enable_n_i(oe_n),
        .chip_enable_n_i(ce_n), .read_i(rd), .read_bank_i(rbank),
        .cfg_write_i(cfg_wr), .cfg_data_i(cfg_d), .mode_write_i(mode_wr),
        .bank_busy_i(busy), .array_data_i(arr), .data_o(data_o),
        .data_oe_n_o(data_oe_n_o), .ready_busy_n_o(ready_busy_n_o),
        .abort_o(abort_o), .array_read_o(array_read_o),
        .cmd_accept_o(cmd_accept_o), .cfg_o(cfg_o),
        .bank_ready_o(bank_ready_o));

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task summarize;
        $display("comparisons=%0d mismatches=%0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    function logic sig(input int s);
        case (s)
            0: return bank_ready_o[0];
            1: return bank_ready_o[1];
            2: return ready_busy_n_o;
            default: return cmd_accept_o;
        endcase
    endfunction

    // Bounded wait; running out ends the run as a mismatch
    task wait_for(input int s, input logic lvl);
        n = 0;
        while (sig(s) !== lvl) begin
            @(negedge clock_i);
            if (++n > 3000) begin
                n_fail++;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time,
                         sig(s), lvl);
                summarize();
            end
        end
    endtask

    // Host pulls the pin at edge B; the block reacts at once, and its
    // timers take the busy flags at edge C, so busy stands until then
    task pin_reset(input logic [1:0] b, input logic [7:0] len);
        @(posedge clock_i);
        start <= 1'b1;
        plen  <= len;
        busy  <= b;
        @(posedge clock_i);
        start <= 1'b0;
        @(negedge clock_i);
        chk({abort_o, data_oe_n_o, cmd_accept_o}, 32'h6);
        @(posedge clock_i);
        busy  <= 2'h0; // Core aborts, the level drops
        @(negedge clock_i);
        t0 = cyc;
    endtask

    task cfg(input logic [15:0] d);
        @(posedge clock_i);
        cfg_wr <= 1'b1;
        cfg_d  <= d;
        @(posedge clock_i);
        cfg_wr <= 1'b0;
        @(posedge clock_i);
        @(negedge clock_i);
    endtask

    initial begin
        n = $urandom(87);
        repeat (5) @(posedge clock_i);
        rst_i <= 1'b0;
        wait_for(3, 1'b1);
        chk({cfg_o, array_read_o, data_oe_n_o}, 32'h3);
        $display("test power-up done");
        // Leave array read and load config, then reset with banks idle
        v = 16'($urandom);
        cfg(v);
        chk(cfg_o, v);
        @(posedge clock_i) mode_wr <= 1'b1;
        @(posedge clock_i) mode_wr <= 1'b0;
        repeat (2) @(negedge clock_i);
        chk(array_read_o, 1'b0);
        pin_reset(2'h0, 8'd30);
        cfg(16'h5a5a); // Ignored while the pin is low
        chk({cfg_o, array_read_o}, 32'h1);
        wait_for(0, 1'b1);
        chk(cyc - t0 <= 101 && ready_busy_n_o === 1'b1, 1);
        wait_for(3, 1'b1);
        cfg(v);
        chk(cfg_o, v);
        $display("test idle reset done");
        // Reset while bank 1 erases: bank 0 soon readable, bank 1 later
        pin_reset(2'h2, 8'd10);
        repeat (3) @(negedge clock_i);
        chk(ready_busy_n_o, 1'b0);
        wait_for(0, 1'b1);
        chk({cyc - t0 <= 101, bank_ready_o[1]}, 32'h2);
        wait_for(2, 1'b1);
        chk(cyc - t0 >= 200 && cyc - t0 <= 1402, 1);
        while (cyc - t0 < 2200) @(negedge clock_i);
        chk(bank_ready_o, 2'h3);
        $display("test busy reset done");
        // Random reads with output enable toggled
        repeat (8) begin
            @(posedge clock_i);
            rbank <= 1'($urandom);
            arr   <= $urandom;
            oe_n  <= 1'b0;
            ce_n  <= 1'b0;
            repeat (2) @(posedge clock_i);
            @(negedge clock_i);
            chk(data_oe_n_o, 1'b0);
            chk(data_o, arr);
            @(posedge clock_i) oe_n <= 1'b1;
            repeat (2) @(posedge clock_i);
            @(negedge clock_i);
            chk(data_oe_n_o, 1'b1);
        end
        oe_n <= 1'b0;
        pin_reset(2'h1, 8'd5); // Reset during a read floats the pins
        wait_for(3, 1'b1);
        $display("test reads done");
        summarize();
    end
endmodule // testbench
`default_nettype wire
